// ===== tws_pkg.sv
// constants, register map and state type of the two-wire slave transmitter
package tws_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_DATA = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_OWN_ADDR = 8'h0C;

  // ----------------------------------------------------------------
  // control register fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_FLAG = 7;
  localparam int CTRL_ACK_EN = 6;
  localparam int CTRL_START = 5;
  localparam int CTRL_STOP = 4;
  localparam int CTRL_ENABLE = 2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;

  // ----------------------------------------------------------------
  // status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_OWN_READ = 8'hA8;
  localparam logic [7:0] ST_ARB_READ = 8'hB0;
  localparam logic [7:0] ST_DATA_ACK = 8'hB8;
  localparam logic [7:0] ST_DATA_NACK = 8'hC0;
  localparam logic [7:0] ST_LAST_ACK = 8'hC8;
  localparam logic [7:0] ST_IDLE = 8'hF8;
  localparam logic [7:0] ST_BUS_ERR = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int START_HOLD_NS = 4000;
  localparam int START_HOLD_CYC = (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_HOLD,
    S_TX,
    S_TX_ACK,
    S_DONE,
    S_BUSERR
  } tws_state_e;

endpackage

// ===== tws_sync.sv
// two-flop synchroniser for lines arriving from outside the clock domain
`timescale 1ns/1ps

module tws_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  if (W < 1) begin : gBadW
    $error("tws_sync width must be at least one");
  end

  // idle bus lines float high, so reset to ones
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '1;
      q <= '1;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ===== tws_slave_tx.sv
// two-wire slave transmitter engine with status codes, behind an APB slave
`timescale 1ns/1ps

module tws_slave_tx #(
  parameter int unsigned HOLD_CYC = tws_pkg::START_HOLD_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tws_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic arbLost,
  output logic masterStart
);

  if (HOLD_CYC < 1 || HOLD_CYC > 300) begin : gHoldBad
    $error("HOLD_CYC must lie between 1 and 300");
  end

  localparam logic [9:0] PH1 = 10'(HOLD_CYC);
  localparam logic [9:0] PH2 = 10'(2 * HOLD_CYC);
  localparam logic [9:0] PH3 = 10'(3 * HOLD_CYC);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  tws_pkg::tws_state_e state_q;
  logic [1:0] pinS;
  logic sclS, sdaS, sclP_q, sdaP_q;
  logic sclRise, sclFall, startCond, stopCond;
  logic pready_q, pslverr_q, lineLow_q, sclOe_q, sdaOe_q, masterStart_q;
  logic [31:0] prdata_q;
  logic [7:0] data_q, ownAddr_q, code_q, shift_q, readMux, statusRead;
  logic flag_q, ackEn_q, startReq_q, stopReq_q, en_q;
  logic [3:0] bitCnt_q;
  logic [9:0] startCnt_q;
  logic last_q, ackSeen_q, arbPend_q, busy_q, startPend_q;
  logic setupPh, accessWr, ctrlWr, clrEv, mapped;
  logic inFrame, busErr, setEv, addrHit, startLaunch;
  logic [7:0] setCode;

  // ----------------------------------------------------------------
  // pin sampling and condition detection
  // ----------------------------------------------------------------
  tws_sync #(
    .W(2)
  ) uSync (
    .clock(clock),
    .rst(rst),
    .d({sclIn, sdaIn}),
    .q(pinS)
  );

  assign sclS = pinS[1];
  assign sdaS = pinS[0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclP_q <= 1'b1;
      sdaP_q <= 1'b1;
    end else begin
      sclP_q <= sclS;
      sdaP_q <= sdaS;
    end
  end

  assign sclRise = sclS & ~sclP_q;
  assign sclFall = ~sclS & sclP_q;
  assign startCond = sclS & sclP_q & sdaP_q & ~sdaS;
  assign stopCond = sclS & sclP_q & ~sdaP_q & sdaS;

  // ----------------------------------------------------------------
  // APB slave: zero wait states, answer in the first access cycle
  // ----------------------------------------------------------------
  assign setupPh = psel & ~penable;
  assign accessWr = psel & penable & pready_q & pwrite;
  assign ctrlWr = accessWr && (paddr == tws_pkg::REG_CTRL);
  assign clrEv = ctrlWr && pwdata[tws_pkg::CTRL_FLAG];

  // low bits masked; a stale code never shows while the flag is down
  assign statusRead = flag_q ? {code_q[7:2], 2'b00} : tws_pkg::ST_IDLE;

  always_comb begin
    readMux = 8'h00;
    mapped = 1'b1;
    case (paddr)
      tws_pkg::REG_DATA: readMux = data_q;
      tws_pkg::REG_STATUS: readMux = statusRead;
      tws_pkg::REG_CTRL: begin
        readMux = {flag_q, ackEn_q, startReq_q, stopReq_q, 1'b0, en_q, 2'b00};
      end
      tws_pkg::REG_OWN_ADDR: readMux = ownAddr_q;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setupPh;
      pslverr_q <= setupPh & ~mapped;
      if (setupPh) begin
        prdata_q <= {24'h00_0000, readMux};
      end
    end
  end

  // data register is plain software storage, never refreshed from the bus
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_q <= tws_pkg::DATA_RST;
      ownAddr_q <= tws_pkg::OWN_ADDR_RST;
    end else if (accessWr) begin
      if (paddr == tws_pkg::REG_DATA) begin
        data_q <= pwdata[7:0];
      end
      if (paddr == tws_pkg::REG_OWN_ADDR) begin
        ownAddr_q <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // events that raise the flag
  // ----------------------------------------------------------------
  // general call is a write address, so it never leads into this engine
  assign addrHit = (shift_q[6:0] == ownAddr_q[7:1]) && sdaS && ackEn_q;
  assign startLaunch = en_q && (state_q == tws_pkg::S_IDLE) && (startCnt_q == 10'd0)
    && startPend_q && !busy_q;

  always_comb begin
    inFrame = ((state_q == tws_pkg::S_ADDR) && (bitCnt_q != 4'd0))
      || (state_q == tws_pkg::S_ADDR_ACK) || (state_q == tws_pkg::S_TX)
      || (state_q == tws_pkg::S_TX_ACK);
    busErr = en_q && inFrame && (startCond || stopCond);
    setEv = 1'b0;
    setCode = tws_pkg::ST_IDLE;
    if (busErr) begin
      setEv = 1'b1;
      setCode = tws_pkg::ST_BUS_ERR;
    end else if (sclFall && bitCnt_q == 4'd9 && state_q == tws_pkg::S_ADDR_ACK) begin
      setEv = 1'b1;
      setCode = arbPend_q ? tws_pkg::ST_ARB_READ : tws_pkg::ST_OWN_READ;
    end else if (sclFall && bitCnt_q == 4'd9 && state_q == tws_pkg::S_TX_ACK) begin
      setEv = 1'b1;
      if (!ackSeen_q) begin
        setCode = tws_pkg::ST_DATA_NACK;
      end else if (last_q) begin
        setCode = tws_pkg::ST_LAST_ACK;
      end else begin
        setCode = tws_pkg::ST_DATA_ACK;
      end
    end
  end

  // ----------------------------------------------------------------
  // flag, status code and control bits
  // ----------------------------------------------------------------
  // a new event in the clearing cycle must not be lost, so set wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_q <= tws_pkg::CTRL_RST[tws_pkg::CTRL_FLAG];
      code_q <= tws_pkg::ST_IDLE;
    end else if (setEv) begin
      flag_q <= 1'b1;
      code_q <= setCode;
    end else if (clrEv) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ackEn_q <= tws_pkg::CTRL_RST[tws_pkg::CTRL_ACK_EN];
      startReq_q <= tws_pkg::CTRL_RST[tws_pkg::CTRL_START];
      stopReq_q <= tws_pkg::CTRL_RST[tws_pkg::CTRL_STOP];
      en_q <= tws_pkg::CTRL_RST[tws_pkg::CTRL_ENABLE];
    end else if (ctrlWr) begin
      ackEn_q <= pwdata[tws_pkg::CTRL_ACK_EN];
      startReq_q <= pwdata[tws_pkg::CTRL_START];
      en_q <= pwdata[tws_pkg::CTRL_ENABLE];
      stopReq_q <= pwdata[tws_pkg::CTRL_STOP]
        && !(clrEv && state_q == tws_pkg::S_BUSERR);
    end
  end

  // ----------------------------------------------------------------
  // bus bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (startCond) begin
      busy_q <= 1'b1;
    end else if (stopCond) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arbPend_q <= 1'b0;
    end else if (arbLost) begin
      arbPend_q <= 1'b1;
    end else if (stopCond || (setEv && state_q == tws_pkg::S_ADDR_ACK)) begin
      arbPend_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      startPend_q <= 1'b0;
    end else if (state_q == tws_pkg::S_DONE && clrEv && pwdata[tws_pkg::CTRL_START]) begin
      startPend_q <= 1'b1;
    end else if (startLaunch) begin
      startPend_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      masterStart_q <= 1'b0;
      lineLow_q <= 1'b0;
    end else begin
      masterStart_q <= (state_q == tws_pkg::S_IDLE) && (startCnt_q == PH3);
      lineLow_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transfer engine
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= tws_pkg::S_IDLE;
      sdaOe_q <= 1'b0;
      sclOe_q <= 1'b0;
      bitCnt_q <= 4'd0;
      startCnt_q <= 10'd0;
      shift_q <= 8'h00;
      last_q <= 1'b0;
      ackSeen_q <= 1'b0;
    end else if (!en_q) begin
      state_q <= tws_pkg::S_IDLE;
      sdaOe_q <= 1'b0;
      sclOe_q <= 1'b0;
      bitCnt_q <= 4'd0;
      startCnt_q <= 10'd0;
    end else if (busErr) begin
      state_q <= tws_pkg::S_BUSERR;
      sdaOe_q <= 1'b0;
      sclOe_q <= 1'b0;
    end else begin
      case (state_q)
        tws_pkg::S_IDLE: begin
          // start: data low, then clock low, then data up, then hand over
          if (startCnt_q != 10'd0) begin
            startCnt_q <= (startCnt_q == PH3) ? 10'd0 : startCnt_q + 10'd1;
            if (startCnt_q == PH1) begin
              sclOe_q <= 1'b1;
            end
            if (startCnt_q == PH2) begin
              sdaOe_q <= 1'b0;
            end
            if (startCnt_q == PH3) begin
              sclOe_q <= 1'b0;
            end
          end else if (startLaunch) begin
            startCnt_q <= 10'd1;
            sdaOe_q <= 1'b1;
          end else if (startCond) begin
            state_q <= tws_pkg::S_ADDR;
            bitCnt_q <= 4'd0;
          end
        end
        tws_pkg::S_ADDR: begin
          if (startCond) begin
            bitCnt_q <= 4'd0;
          end else if (sclRise) begin
            shift_q <= {shift_q[6:0], sdaS};
            bitCnt_q <= bitCnt_q + 4'd1;
            if (bitCnt_q == 4'd7) begin
              state_q <= addrHit ? tws_pkg::S_ADDR_ACK : tws_pkg::S_IDLE;
            end
          end
        end
        tws_pkg::S_ADDR_ACK: begin
          if (sclFall && bitCnt_q == 4'd8) begin
            sdaOe_q <= 1'b1;
          end else if (sclRise) begin
            bitCnt_q <= 4'd9;
          end else if (sclFall) begin
            sdaOe_q <= 1'b0;
            sclOe_q <= 1'b1;
            state_q <= tws_pkg::S_HOLD;
          end
        end
        tws_pkg::S_HOLD: begin
          if (clrEv) begin
            shift_q <= data_q;
            last_q <= ~pwdata[tws_pkg::CTRL_ACK_EN];
            sdaOe_q <= ~data_q[7];
            sclOe_q <= 1'b0;
            bitCnt_q <= 4'd0;
            state_q <= tws_pkg::S_TX;
          end
        end
        tws_pkg::S_TX: begin
          if (sclRise) begin
            bitCnt_q <= bitCnt_q + 4'd1;
          end else if (sclFall && bitCnt_q == 4'd8) begin
            sdaOe_q <= 1'b0;
            state_q <= tws_pkg::S_TX_ACK;
          end else if (sclFall) begin
            shift_q <= {shift_q[6:0], 1'b0};
            sdaOe_q <= ~shift_q[6];
          end
        end
        tws_pkg::S_TX_ACK: begin
          if (sclRise) begin
            ackSeen_q <= ~sdaS;
            bitCnt_q <= 4'd9;
          end else if (sclFall && bitCnt_q == 4'd9) begin
            sclOe_q <= 1'b1;
            state_q <= (ackSeen_q && !last_q) ? tws_pkg::S_HOLD : tws_pkg::S_DONE;
          end
        end
        tws_pkg::S_DONE: begin
          // clock stays held low here until the flag clear, data stays released, so further reads see all ones
          if (clrEv) begin
            sclOe_q <= 1'b0;
            state_q <= tws_pkg::S_IDLE;
          end
        end
        tws_pkg::S_BUSERR: begin
          if (clrEv && pwdata[tws_pkg::CTRL_STOP]) begin
            state_q <= tws_pkg::S_IDLE;
          end
        end
        default: state_q <= tws_pkg::S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sclOut = lineLow_q;
  assign sdaOut = lineLow_q;
  assign sclOe = sclOe_q;
  assign sdaOe = sdaOe_q;
  assign masterStart = masterStart_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  idle_code_a: assert property (
    psel && !penable && paddr == tws_pkg::REG_STATUS && !flag_q
    |=> prdata[7:0] == tws_pkg::ST_IDLE)
    else $error("status shows a code while flag is clear");
  own_read_a: assert property (
    state_q == tws_pkg::S_ADDR_ACK && sclFall && bitCnt_q == 4'd9 && !arbPend_q
    |=> flag_q && code_q == tws_pkg::ST_OWN_READ && state_q == tws_pkg::S_HOLD)
    else $error("own read address did not report its code");
  arb_read_a: assert property (
    state_q == tws_pkg::S_ADDR_ACK && sclFall && bitCnt_q == 4'd9 && arbPend_q
    |=> flag_q && code_q == tws_pkg::ST_ARB_READ)
    else $error("read after lost arbitration did not report its code");
  ack_data_a: assert property (
    state_q == tws_pkg::S_TX_ACK && sclFall && bitCnt_q == 4'd9 && ackSeen_q && !last_q
    |=> code_q == tws_pkg::ST_DATA_ACK && state_q == tws_pkg::S_HOLD)
    else $error("acknowledged byte did not report its code");
  nack_data_a: assert property (
    state_q == tws_pkg::S_TX_ACK && sclFall && bitCnt_q == 4'd9 && !ackSeen_q
    |=> code_q == tws_pkg::ST_DATA_NACK && state_q == tws_pkg::S_DONE)
    else $error("refused byte did not report its code");
  last_ack_a: assert property (
    state_q == tws_pkg::S_TX_ACK && sclFall && bitCnt_q == 4'd9 && ackSeen_q && last_q
    |=> code_q == tws_pkg::ST_LAST_ACK && state_q == tws_pkg::S_DONE)
    else $error("acknowledged final byte did not report its code");
  tx_load_a: assert property (
    state_q == tws_pkg::S_HOLD && clrEv && pwdata[tws_pkg::CTRL_ACK_EN]
    |=> state_q == tws_pkg::S_TX && !last_q && shift_q == $past(data_q) && !sclOe_q)
    else $error("loaded byte not sent as a normal byte");
  start_req_a: assert property (
    state_q == tws_pkg::S_DONE && clrEv && pwdata[tws_pkg::CTRL_START] && en_q
    |=> startPend_q && state_q == tws_pkg::S_IDLE)
    else $error("start request lost at flag clear");
  bus_err_a: assert property (busErr |=> flag_q && code_q == tws_pkg::ST_BUS_ERR)
    else $error("bus error did not report its code");
  w1c_flag_a: assert property (
    flag_q && ctrlWr && !pwdata[tws_pkg::CTRL_FLAG] |=> flag_q)
    else $error("writing zero cleared the flag");
  recover_a: assert property (
    state_q == tws_pkg::S_BUSERR && clrEv && pwdata[tws_pkg::CTRL_STOP] && en_q
    |=> state_q == tws_pkg::S_IDLE && !stopReq_q && ackEn_q == $past(pwdata[tws_pkg::CTRL_ACK_EN]))
    else $error("bus error recovery did not restore control state");
  release_a: assert property (
    state_q == tws_pkg::S_BUSERR |-> !sdaOe_q && !sclOe_q)
    else $error("lines driven during bus error");
  hold_low_a: assert property (
    state_q == tws_pkg::S_HOLD || state_q == tws_pkg::S_DONE |-> sclOe_q && flag_q)
    else $error("clock not held while waiting for software");
  sda_change_a: assert property (
    state_q == tws_pkg::S_TX && $changed(sdaOe_q) |-> !sclS)
    else $error("data changed while clock high");

endmodule

// ===== tws_bus_master.sv
// two-wire bus master receiver model driving open-drain clock and data lines
`timescale 1ns/1ps

module tws_bus_master (
  input wire logic scl,
  input wire logic sda,
  output logic sclLow,
  output logic sdaLow
);
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end

  // sda falls while scl high; issued mid-byte it forces a framing fault
  task automatic start();
    sdaLow = 1'b0;
    #80 sclLow = 1'b0;
    wait (scl === 1'b1);
    #160 sdaLow = 1'b1;
    #160 sclLow = 1'b1;
  endtask

  // n bits msb first; a released data bit lets the slave drive, rx holds line levels
  task automatic bits(input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = '1;
    for (int i = 8; i > 8 - n; i--) begin
      #80 sdaLow = !tx[i];
      #80 sclLow = 1'b0;
      // slave may stretch the clock low while its flag is up
      wait (scl === 1'b1);
      #160 rx[i] = sda;
      sclLow = 1'b1;
    end
  endtask

  task automatic stop();
    #80 sdaLow = 1'b1;
    #80 sclLow = 1'b0;
    wait (scl === 1'b1);
    #160 sdaLow = 1'b0;
    #160;
  endtask
endmodule

// ===== tb_two_wire_slave_transmit_status.sv
// self-checking bench for the two-wire slave transmitter
`timescale 1ns/1ps

module tb_two_wire_slave_transmit_status;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, arbLost = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, masterStart, mScl, mSda, e;
  logic [8:0] rx;
  logic [7:0] q[$];
  int error_cnt = 0, comparisons = 0, cyc = 0, n;
  // open-drain wires with pull-ups
  wire scl = !(sclOe || mScl);
  wire sda = !(sdaOe || mSda);

  always #20 clock = !clock;

  tws_slave_tx #(.HOLD_CYC(3)) DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .arbLost(arbLost), .masterStart(masterStart));
  tws_bus_master m (.scl(scl), .sda(sda), .sclLow(mScl), .sdaLow(mSda));

  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no fixed wait count: only the bench timeout ends a missing answer
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask

  // flag rises a few clocks after the clock fall, so poll the status
  task automatic waitSt(input logic [7:0] exp);
    n = 0;
    do begin
      apb(1'b0, tws_pkg::REG_STATUS, 32'h0000_0000);
      n++;
    end while (r[7:0] === tws_pkg::ST_IDLE && n < 30);
    chk(r, {24'h0000_00, exp});
    if (exp !== tws_pkg::ST_BUS_ERR) chk(sclOe, 1'b1);
  endtask

  task automatic addr();
    m.start();
    m.bits(9'h16B, 9, rx);
    chk(rx[0], 1'b0);
  endtask

  // reference model: queued bytes and status from acknowledge and final marking
  task automatic sendByte(input logic [7:0] d, input bit fin, input bit mAck);
    q.push_back(d);
    apb(1'b1, tws_pkg::REG_DATA, {24'h0000_00, d});
    apb(1'b1, tws_pkg::REG_CTRL, fin ? 32'h0000_0084 : 32'h0000_00C4);
    m.bits({8'hFF, !mAck}, 9, rx);
    chk(rx[8:1], q.pop_front());
    waitSt(!mAck ? tws_pkg::ST_DATA_NACK : fin ? tws_pkg::ST_LAST_ACK : tws_pkg::ST_DATA_ACK);
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(22296));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd(tws_pkg::REG_STATUS, 32'h0000_00F8);
    rd(tws_pkg::REG_CTRL, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    chk(e, 1'b1);
    apb(1'b1, tws_pkg::REG_OWN_ADDR, 32'h0000_00B4);
    apb(1'b1, tws_pkg::REG_CTRL, 32'h0000_0044);
    addr();
    waitSt(tws_pkg::ST_OWN_READ);
    apb(1'b1, tws_pkg::REG_CTRL, 32'h0000_0044);
    rd(tws_pkg::REG_STATUS, 32'h0000_00A8);
    sendByte(8'($urandom), 0, 1);
    sendByte(8'($urandom), 0, 1);
    sendByte(8'($urandom), 1, 0);
    apb(1'b1, tws_pkg::REG_CTRL, 32'h0000_00C4);
    rd(tws_pkg::REG_STATUS, 32'h0000_00F8);
    m.stop();
    // line model returns on an edge time step; align before driving the pulse
    @(posedge clock);
    arbLost <= 1'b1;
    @(posedge clock);
    arbLost <= 1'b0;
    addr();
    waitSt(tws_pkg::ST_ARB_READ);
    sendByte(8'($urandom), 1, 1);
    apb(1'b1, tws_pkg::REG_CTRL, 32'h0000_0084);
    m.bits(9'h1FF, 9, rx);
    chk(rx, 9'h1FF);
    m.stop();
    m.start();
    m.bits(9'h16B, 9, rx);
    chk(rx[0], 1'b1);
    m.stop();
    apb(1'b1, tws_pkg::REG_CTRL, 32'h0000_0044);
    addr();
    waitSt(tws_pkg::ST_OWN_READ);
    apb(1'b1, tws_pkg::REG_DATA, 32'h0000_00FF);
    apb(1'b1, tws_pkg::REG_CTRL, 32'h0000_00C4);
    m.bits(9'h1FF, 3, rx);
    m.start();
    waitSt(tws_pkg::ST_BUS_ERR);
    chk({sclOe, sdaOe}, 2'b00);
    chk({sclOut, sdaOut}, 2'b00);
    apb(1'b1, tws_pkg::REG_CTRL, 32'h0000_00D4);
    rd(tws_pkg::REG_CTRL, 32'h0000_0044);
    m.stop();
    addr();
    waitSt(tws_pkg::ST_OWN_READ);
    sendByte(8'($urandom), 1, 0);
    apb(1'b1, tws_pkg::REG_CTRL, 32'h0000_00E4);
    m.stop();
    n = 0;
    while (masterStart !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    chk(masterStart, 1'b1);
    finish_test();
  end
endmodule
